// ===== fbl_host_model.sv
// partner: host controller that frames commands on the serial link
`timescale 1ns/10ps
module fbl_host_model (
  // link driven by the host
  output logic            spi_clk,
  output logic            chip_select_n,
  output logic            serial_data_in,
  // device answer
  input  wire logic       serial_data_out,
  input  wire logic       serial_data_out_oe
);
  // cs rises after time zero so the link flops see a real edge and leave their unknown state
  initial begin
    spi_clk = 1'b0;
    serial_data_in = 1'b0;
    #1 chip_select_n = 1'b1;
  end

  //----------------------------------------------------------------------------
  // frame: n clocks, first 32 bits msb first, later clocks sample the answer
  //----------------------------------------------------------------------------
  task automatic frame(input logic [31:0] word, input int n, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    #3 chip_select_n = 1'b0;
    #10;
    for (i = 0; i < n; i++) begin
      // past the address the input is don't-care, so it keeps toggling
      serial_data_in = (i < 32) ? word[31 - i] : ~serial_data_in;
      #15 spi_clk = 1'b1;
      if (i >= 32) rd = {rd[6:0], serial_data_out};
      #15 spi_clk = 1'b0;
    end
    #10 chip_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    // clock stands still between frames; gap well above five system cycles
    #100;
  endtask : frame
endmodule : fbl_host_model

// ===== fbl_pkg.sv
// package: opcodes, frame layout, timing and state types for the flash block lock logic
//------------------------------------------------------------------------------
// Contract
// - 36h plus 24-bit address locks one region
// - 39h plus 24-bit address unlocks one region
// - 3Dh plus address returns lock byte, MSB first
// - returned LSB is 1 locked, 0 unlocked
// - 7Eh with no address locks every region
// - 98h with no address unlocks every region
// - lock commands ignored unless write enable latch set
// - lock bits govern only when scheme select is 1
// - lock bits volatile, all 1 after any reset
// - software reset needs 66h then 99h
// - other command after 66h cancels reset enable
// - accepted reset aborts work, clears volatile state
// - all commands rejected for about 30us after reset
//------------------------------------------------------------------------------
package fbl_pkg;

  //----------------------------------------------------------------------------
  // opcodes
  //----------------------------------------------------------------------------
  localparam logic [7:0] OP_LOCK_ONE     = 8'h36;
  localparam logic [7:0] OP_UNLOCK_ONE   = 8'h39;
  localparam logic [7:0] OP_READ_LOCK    = 8'h3D;
  localparam logic [7:0] OP_LOCK_ALL     = 8'h7E;
  localparam logic [7:0] OP_UNLOCK_ALL   = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE = 8'h99;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISBL  = 8'h04;

  //----------------------------------------------------------------------------
  // frame bit counts and field positions
  //----------------------------------------------------------------------------
  localparam logic [5:0] CNT_OPCODE    = 6'h08;
  localparam logic [5:0] CNT_ADDR      = 6'h20;
  localparam logic [5:0] CNT_OP_LAST   = 6'h07;
  localparam logic [5:0] CNT_ADDR_LAST = 6'h1F;
  localparam logic [5:0] CNT_FIRST     = 6'h01;
  localparam logic [5:0] CNT_SAT       = 6'h3F;
  localparam logic [2:0] OUT_LSB_POS   = 3'h7;
  localparam int         REGION_LSB    = 16;
  localparam int         SECTOR_LSB    = 12;

  //----------------------------------------------------------------------------
  // reset values and timing
  //----------------------------------------------------------------------------
  localparam logic       LOCK_RESET_VAL      = 1'b1;
  localparam int         CLK_PERIOD_NS       = 10;
  localparam int         RST_RECOVERY_NS     = 30000;
  localparam int         RST_RECOVERY_CYCLES = (RST_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  //----------------------------------------------------------------------------
  // types
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
  } fbl_frame_t;

  typedef enum logic [0:0] {
    FBL_READY   = 1'b0,
    FBL_RECOVER = 1'b1
  } fbl_state_t;

endpackage : fbl_pkg

// ===== fbl_top.sv
// module: serial command decode, volatile region lock bits and software reset sequence
`timescale 1ns/10ps
module fbl_top #(
  parameter int REGION_BITS     = 6,
  parameter int RECOVERY_CYCLES = fbl_pkg::RST_RECOVERY_CYCLES
) (
  // system clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // serial link, clocked by the host
  input  wire logic        spi_clk,
  input  wire logic        chip_select_n,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  // legacy protection configuration
  input  wire logic        protect_scheme_select,
  input  wire logic        complement_protect,
  input  wire logic        block_size_select,
  input  wire logic        top_bottom_select,
  input  wire logic [2:0]  block_protect_bits,
  // protection query from the erase and program path
  input  wire logic [23:0] check_addr,
  output logic             check_protected,
  // status towards the rest of the device
  output logic             write_enable_latch,
  output logic             reset_recovery_busy,
  output logic             soft_reset_pulse
);

  localparam int NUM_REGIONS = 1 << REGION_BITS;

  //----------------------------------------------------------------------------
  // link domain: shift in on rising spi_clk
  //----------------------------------------------------------------------------
  logic                first_q;
  logic [5:0]          cnt_q;
  logic [31:0]         shift_q;
  logic [7:0]          op_hold_q;
  logic [23:0]         addr_hold_q;
  logic                rd_req_q;

  // first edge of a frame restarts the count; cs high is the only async event
  always_ff @(posedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge spi_clk) begin
    shift_q <= {shift_q[30:0], serial_data_in};
    if (first_q) begin
      cnt_q <= fbl_pkg::CNT_FIRST;
    end else if (cnt_q != fbl_pkg::CNT_SAT) begin
      cnt_q <= cnt_q + fbl_pkg::CNT_FIRST;
    end
  end

  // hold copies stay still until the next frame, so the system side reads them safely
  always_ff @(posedge spi_clk) begin
    if (!first_q && cnt_q == fbl_pkg::CNT_OP_LAST) begin
      op_hold_q <= {shift_q[6:0], serial_data_in};
    end
    if (!first_q && cnt_q == fbl_pkg::CNT_ADDR_LAST) begin
      addr_hold_q <= {shift_q[22:0], serial_data_in};
    end
  end

  // lock read request raised after the last address bit, dropped by cs high
  always_ff @(posedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      rd_req_q <= 1'b0;
    end else if (!first_q && cnt_q == fbl_pkg::CNT_ADDR_LAST && op_hold_q == fbl_pkg::OP_READ_LOCK) begin
      rd_req_q <= 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // link domain: shift out on falling spi_clk
  //----------------------------------------------------------------------------
  logic                ack_s1_q;
  logic                ack_s2_q;
  logic                lock_val_q;
  logic [2:0]          out_pos_q;
  logic                do_q;
  logic                oe_q;
  logic                rd_bit_q;
  logic                rd_ack_q;

  always_ff @(negedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      ack_s1_q   <= 1'b0;
      ack_s2_q   <= 1'b0;
      lock_val_q <= 1'b0;
    end else begin
      ack_s1_q <= rd_ack_q;
      ack_s2_q <= ack_s1_q;
      // rd_bit_q is held steady by the system side while the ack is high
      if (ack_s2_q) begin
        lock_val_q <= rd_bit_q;
      end
    end
  end

  // byte is 0000000L repeated while cs stays low; LSB comes 7 edges late, which covers the crossing
  always_ff @(negedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      out_pos_q <= 3'h0;
      do_q      <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      oe_q <= rd_req_q;
      if (rd_req_q) begin
        out_pos_q <= out_pos_q + 3'h1;
        do_q      <= (out_pos_q == fbl_pkg::OUT_LSB_POS) & lock_val_q;
      end
    end
  end

  assign serial_data_out    = do_q;
  assign serial_data_out_oe = oe_q;

  //----------------------------------------------------------------------------
  // system domain: synchronisers
  //----------------------------------------------------------------------------
  logic                cs_s1_q;
  logic                cs_s2_q;
  logic                cs_s3_q;
  logic                rd_s1_q;
  logic                rd_s2_q;
  logic                frame_end;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= chip_select_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      rd_s1_q <= rd_req_q;
      rd_s2_q <= rd_s1_q;
    end
  end

  assign frame_end = cs_s2_q & ~cs_s3_q;

  //----------------------------------------------------------------------------
  // system domain: command decode at the end of a frame
  //----------------------------------------------------------------------------
  fbl_pkg::fbl_frame_t frame;
  fbl_pkg::fbl_state_t state_q;
  logic                ready;
  logic                any_cmd;
  logic                short_ok;
  logic                long_ok;
  logic                do_lock_one;
  logic                do_unlock_one;
  logic                do_lock_all;
  logic                do_unlock_all;
  logic                do_reset;
  logic                reset_enable_q;
  logic [REGION_BITS-1:0] cmd_idx;

  // link values are quiet here: the host gives no spi_clk edge while cs is high
  assign frame.opcode = op_hold_q;
  assign frame.addr   = addr_hold_q;

  assign ready    = (state_q == fbl_pkg::FBL_READY);
  assign any_cmd  = ready & frame_end & (cnt_q >= fbl_pkg::CNT_OPCODE);
  assign short_ok = any_cmd & (cnt_q == fbl_pkg::CNT_OPCODE);
  assign long_ok  = any_cmd & (cnt_q == fbl_pkg::CNT_ADDR);
  assign cmd_idx  = frame.addr[fbl_pkg::REGION_LSB +: REGION_BITS];

  assign do_lock_one   = long_ok & write_enable_latch & (frame.opcode == fbl_pkg::OP_LOCK_ONE);
  assign do_unlock_one = long_ok & write_enable_latch & (frame.opcode == fbl_pkg::OP_UNLOCK_ONE);
  assign do_lock_all   = short_ok & write_enable_latch & (frame.opcode == fbl_pkg::OP_LOCK_ALL);
  assign do_unlock_all = short_ok & write_enable_latch & (frame.opcode == fbl_pkg::OP_UNLOCK_ALL);
  assign do_reset      = short_ok & reset_enable_q & (frame.opcode == fbl_pkg::OP_RESET_DEVICE);

  //----------------------------------------------------------------------------
  // reset sequence and recovery
  //----------------------------------------------------------------------------
  logic [12:0]         rec_cnt_q;

  // any completed command re-arms or cancels the enable
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reset_enable_q <= 1'b0;
    end else if (do_reset) begin
      reset_enable_q <= 1'b0;
    end else if (any_cmd) begin
      reset_enable_q <= short_ok & (frame.opcode == fbl_pkg::OP_RESET_ENABLE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q   <= fbl_pkg::FBL_READY;
      rec_cnt_q <= 13'h0000;
    end else begin
      unique case (state_q)
        fbl_pkg::FBL_READY: begin
          if (do_reset) begin
            state_q   <= fbl_pkg::FBL_RECOVER;
            rec_cnt_q <= 13'(RECOVERY_CYCLES - 1);
          end
        end
        fbl_pkg::FBL_RECOVER: begin
          if (rec_cnt_q == 13'h0000) begin
            state_q <= fbl_pkg::FBL_READY;
          end else begin
            rec_cnt_q <= rec_cnt_q - 13'h0001;
          end
        end
      endcase
    end
  end

  assign reset_recovery_busy = ~ready;

  // tells the owners of status, suspend, read, mode and wrap bits to return to power-on values
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= do_reset;
    end
  end

  //----------------------------------------------------------------------------
  // write enable latch
  //----------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (do_reset) begin
      write_enable_latch <= 1'b0;
    end else if (short_ok && frame.opcode == fbl_pkg::OP_WRITE_ENABLE) begin
      write_enable_latch <= 1'b1;
    end else if (short_ok && frame.opcode == fbl_pkg::OP_WRITE_DISBL) begin
      write_enable_latch <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // lock bits
  //----------------------------------------------------------------------------
  logic [NUM_REGIONS-1:0] lock_q;

  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_lock
    always_ff @(posedge ref_clk) begin
      if (!rst_n || do_reset || do_lock_all) begin
        lock_q[g] <= fbl_pkg::LOCK_RESET_VAL;
      end else if (do_unlock_all) begin
        lock_q[g] <= 1'b0;
      end else if (do_lock_one && cmd_idx == REGION_BITS'(g)) begin
        lock_q[g] <= 1'b1;
      end else if (do_unlock_one && cmd_idx == REGION_BITS'(g)) begin
        lock_q[g] <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------------
  // lock read answer towards the link
  //----------------------------------------------------------------------------
  // no answer during recovery, so a read then returns 00h
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_ack_q <= 1'b0;
      rd_bit_q <= 1'b0;
    end else if (!rd_s2_q) begin
      rd_ack_q <= 1'b0;
    end else if (ready && !rd_ack_q) begin
      rd_bit_q <= lock_q[cmd_idx];
      rd_ack_q <= 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // protection query
  //----------------------------------------------------------------------------
  logic [REGION_BITS-1:0] q_idx;
  logic [REGION_BITS-1:0] q_pos;
  logic [3:0]             q_sec;
  logic [REGION_BITS:0]   span;
  logic                   legacy_hit;

  assign q_idx = check_addr[fbl_pkg::REGION_LSB +: REGION_BITS];

  // simple edge-range reading of the legacy bits: bottom when top_bottom_select is 1
  always_comb begin
    q_pos      = top_bottom_select ? q_idx : ~q_idx;
    q_sec      = top_bottom_select ? check_addr[fbl_pkg::SECTOR_LSB +: 4] : ~check_addr[fbl_pkg::SECTOR_LSB +: 4];
    span       = '0;
    legacy_hit = 1'b0;
    if (block_protect_bits != 3'h0) begin
      span = (REGION_BITS + 1)'(1) << (block_protect_bits - 3'h1);
      if (block_size_select) begin
        legacy_hit = (q_pos == '0) && ({{(REGION_BITS - 3){1'b0}}, q_sec} < span);
      end else begin
        legacy_hit = ({1'b0, q_pos} < span);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      check_protected <= 1'b1;
    end else if (protect_scheme_select) begin
      check_protected <= lock_q[q_idx];
    end else begin
      check_protected <= legacy_hit ^ complement_protect;
    end
  end

endmodule : fbl_top

// ===== fbl_top_sva.sv
// checker: concurrent assertions on the lock block ports
`timescale 1ns/10ps
module fbl_top_sva #(
  parameter int RECOVERY_CYCLES = 3000
) (
  // system
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  input wire logic chip_select_n,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  // status
  input wire logic protect_scheme_select,
  input wire logic check_protected,
  input wire logic write_enable_latch,
  input wire logic reset_recovery_busy,
  input wire logic soft_reset_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] busy_cnt_q;

  // recovery is far longer than a repetition may be, so it is counted
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !reset_recovery_busy) busy_cnt_q <= 16'h0000;
    else busy_cnt_q <= busy_cnt_q + 16'h0001;
  end

  sequence s_pulse_once;
    soft_reset_pulse ##1 !soft_reset_pulse;
  endsequence

  a_reset_state: assert property ($rose(rst_n) |-> check_protected && !write_enable_latch
    && !reset_recovery_busy && !soft_reset_pulse) else $error("state after reset wrong");
  a_rst_pulse: assert property ($rose(reset_recovery_busy) |-> s_pulse_once)
    else $error("reset pulse missing");
  a_pulse_busy: assert property (soft_reset_pulse |-> reset_recovery_busy)
    else $error("pulse outside recovery");
  a_busy_wel: assert property (reset_recovery_busy |-> !write_enable_latch)
    else $error("write enable set in recovery");
  a_busy_len: assert property ($fell(reset_recovery_busy) |-> busy_cnt_q == RECOVERY_CYCLES)
    else $error("recovery length wrong");
  a_busy_max: assert property (busy_cnt_q <= RECOVERY_CYCLES)
    else $error("recovery too long");
  a_cs_idle: assert property (chip_select_n && $past(chip_select_n) |-> !serial_data_out_oe
    && !serial_data_out) else $error("data out driven while idle");
  a_out_oe: assert property (serial_data_out |-> serial_data_out_oe)
    else $error("data out high without enable");
  a_wel_cs: assert property ($changed(write_enable_latch) |-> $past(chip_select_n, 2))
    else $error("write enable changed mid frame");
  a_prot_rst: assert property (soft_reset_pulse && protect_scheme_select |=> check_protected)
    else $error("not protected after reset");
endmodule : fbl_top_sva

bind fbl_top fbl_top_sva #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) fbl_top_sva_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .chip_select_n(chip_select_n),
  .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
  .protect_scheme_select(protect_scheme_select), .check_protected(check_protected),
  .write_enable_latch(write_enable_latch), .reset_recovery_busy(reset_recovery_busy),
  .soft_reset_pulse(soft_reset_pulse));

// ===== tb_top.sv
// testbench: lock commands, write enable gating and software reset
`timescale 1ns/10ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        protect_scheme_select = 1'b1;
  logic        complement_protect = 1'b0;
  logic [2:0]  block_protect_bits = 3'h0;
  logic        soft_reset_pulse;
  int          n_pulses = 0;
  logic [23:0] check_addr = 24'h000000;
  logic        spi_clk, chip_select_n, serial_data_in;
  logic        serial_data_out, serial_data_out_oe;
  logic        check_protected, write_enable_latch, reset_recovery_busy;
  int          n_errors = 0;
  int          checked = 0;

  always #5 ref_clk = ~ref_clk;

  // the pulse stands one cycle, so it is counted where it happens
  always @(posedge ref_clk) if (soft_reset_pulse === 1'b1) n_pulses <= n_pulses + 1;

  // legacy size and direction tied; strength and complement driven by the tests
  fbl_top #(.REGION_BITS(6), .RECOVERY_CYCLES(300)) fbl_top_i (
    .ref_clk, .rst_n, .spi_clk, .chip_select_n, .serial_data_in, .serial_data_out,
    .serial_data_out_oe, .protect_scheme_select, .complement_protect,
    .block_size_select(1'b0), .top_bottom_select(1'b0), .block_protect_bits,
    .check_addr, .check_protected, .write_enable_latch, .reset_recovery_busy,
    .soft_reset_pulse);
  fbl_host_model fbl_host_model_i (
    .spi_clk, .chip_select_n, .serial_data_in, .serial_data_out, .serial_data_out_oe);

  //----------------------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op);
    logic [7:0] rd;
    fbl_host_model_i.frame({op, 24'h000000}, 8, rd);
  endtask : cmd

  task automatic lk(input logic [7:0] op, input logic [5:0] rg);
    logic [7:0] rd;
    fbl_host_model_i.frame({op, 2'b00, rg, 16'h0000}, 32, rd);
  endtask : lk

  task automatic rdlk(input logic [5:0] rg, input logic [7:0] exp);
    logic [7:0] rd;
    fbl_host_model_i.frame({fbl_pkg::OP_READ_LOCK, 2'b00, rg, 16'h0000}, 40, rd);
    chk("lock_byte", exp, rd);
  endtask : rdlk

  task automatic prot(input logic [5:0] rg, input logic exp);
    @(posedge ref_clk);
    check_addr <= {2'b00, rg, 16'h0000};
    repeat (3) @(posedge ref_clk);
    #1 chk("check_protected", {7'h00, exp}, {7'h00, check_protected});
  endtask : prot

  task automatic flag(input string nm, input logic exp, input logic got);
    chk(nm, {7'h00, exp}, {7'h00, got});
  endtask : flag

  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  task automatic t_gate;
    rdlk(6'h05, 8'h01);
    cmd(fbl_pkg::OP_WRITE_DISBL);
    lk(fbl_pkg::OP_UNLOCK_ONE, 6'h05);
    rdlk(6'h05, 8'h01);
    cmd(fbl_pkg::OP_WRITE_ENABLE);
    flag("wel", 1'b1, write_enable_latch);
    lk(fbl_pkg::OP_UNLOCK_ONE, 6'h05);
    rdlk(6'h05, 8'h00);
    rdlk(6'h06, 8'h01);
    prot(6'h05, 1'b0);
    lk(fbl_pkg::OP_LOCK_ONE, 6'h05);
    rdlk(6'h05, 8'h01);
    $display("done t_gate");
  endtask : t_gate

  task automatic t_global;
    cmd(fbl_pkg::OP_UNLOCK_ALL);
    rdlk(6'h00, 8'h00);
    rdlk(6'h3F, 8'h00);
    cmd(fbl_pkg::OP_WRITE_DISBL);
    cmd(fbl_pkg::OP_LOCK_ALL);
    rdlk(6'h00, 8'h00);
    cmd(fbl_pkg::OP_WRITE_ENABLE);
    cmd(fbl_pkg::OP_LOCK_ALL);
    rdlk(6'h3F, 8'h01);
    @(posedge ref_clk);
    protect_scheme_select <= 1'b0;
    prot(6'h3F, 1'b0);
    @(posedge ref_clk);
    complement_protect <= 1'b1;
    prot(6'h3F, 1'b1);
    @(posedge ref_clk);
    complement_protect <= 1'b0;
    block_protect_bits <= 3'h1;
    prot(6'h3F, 1'b1);
    prot(6'h00, 1'b0);
    @(posedge ref_clk);
    block_protect_bits <= 3'h0;
    protect_scheme_select <= 1'b1;
    $display("done t_global");
  endtask : t_global

  task automatic t_soft_reset;
    int i;
    cmd(fbl_pkg::OP_UNLOCK_ALL);
    cmd(fbl_pkg::OP_RESET_ENABLE);
    cmd(fbl_pkg::OP_WRITE_ENABLE);
    cmd(fbl_pkg::OP_RESET_DEVICE);
    flag("busy", 1'b0, reset_recovery_busy);
    chk("pulses", 8'h00, 8'(n_pulses));
    rdlk(6'h09, 8'h00);
    flag("busy", 1'b0, reset_recovery_busy);
    cmd(fbl_pkg::OP_RESET_ENABLE);
    cmd(fbl_pkg::OP_RESET_DEVICE);
    flag("busy", 1'b1, reset_recovery_busy);
    chk("pulses", 8'h01, 8'(n_pulses));
    flag("wel", 1'b0, write_enable_latch);
    rdlk(6'h09, 8'h00);
    cmd(fbl_pkg::OP_WRITE_ENABLE);
    for (i = 0; i < 1000 && reset_recovery_busy !== 1'b0; i++) @(posedge ref_clk);
    flag("busy", 1'b0, reset_recovery_busy);
    flag("wel", 1'b0, write_enable_latch);
    rdlk(6'h09, 8'h01);
    $display("done t_soft_reset");
  endtask : t_soft_reset

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    prot(6'h05, 1'b1);
    t_gate();
    t_global();
    t_soft_reset();
    tally_and_finish();
  end

  // the tests need about 26 us; ten times that means a hang
  initial begin
    #250us;
    n_errors++;
    tally_and_finish();
  end
endmodule : tb_top
